// >>> shared/wpr_consts.vh
// Constants for the watchdog, power and reset control block
`ifndef WPR_CONSTS_VH
`define WPR_CONSTS_VH
// ----------------------------------------------------------------
// APB register map (byte addresses)
// ----------------------------------------------------------------
`define WPR_ADDR_WDT_CTRL 12'h000
`define WPR_ADDR_PWR_CTRL 12'h004
`define WPR_ADDR_STATUS 12'h008
`define WPR_ADDR_WDT_COUNT 12'h00c
// ----------------------------------------------------------------
// Watchdog control fields
// ----------------------------------------------------------------
`define WPR_WDT_ENABLE_BIT 7
`define WPR_WDT_KICK_BIT 6
`define WPR_WDT_IDLE_BIT 5
`define WPR_WDT_PS_HI 2
`define WPR_WDT_PS_LO 0
// ----------------------------------------------------------------
// Power control fields
// ----------------------------------------------------------------
`define WPR_PWR_FLAG_BIT 4
`define WPR_PWR_GF1_BIT 3
`define WPR_PWR_GF0_BIT 2
`define WPR_PWR_DOWN_BIT 1
`define WPR_PWR_IDLE_BIT 0
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define WPR_PORT_RESET 8'hff
`define WPR_SP_RESET 8'h07
`define WPR_SFR_RESET 8'h00
`define WPR_MC_OSC 12
`define WPR_SAMPLE_PHASE 4'h9
`define WPR_RST_MIN_MC 2
`define WPR_WDT_BITS 14
`endif

// >>> rtl/wpr_top.v
// Watchdog, power-mode and reset supervision block with APB registers
`timescale 1ns/1ns
`include "wpr_consts.vh"
module wpr_top (
	CLK_SYS,
	RESETN,
	POR_N,
	EXT_RESET,
	IRQ_PENDING,
	PSEL,
	PENABLE,
	PWRITE,
	PADDR,
	PWDATA,
	PRDATA,
	PREADY,
	PSLVERR,
	CLK_HALF_EN,
	CPU_CLK_EN,
	PERIPH_CLK_EN,
	OSC_RUN,
	SYS_RESET,
	PORT_INIT,
	SP_INIT,
	SFR_INIT,
	SFR_CLEAR,
	SERIAL_BUFFER_HOLD
);
input wire CLK_SYS;
input wire RESETN;
input wire POR_N;
input wire EXT_RESET;
input wire IRQ_PENDING;
input wire PSEL;
input wire PENABLE;
input wire PWRITE;
input wire [11:0] PADDR;
input wire [31:0] PWDATA;
output reg [31:0] PRDATA;
output reg PREADY;
output reg PSLVERR;
output reg CLK_HALF_EN;
output reg CPU_CLK_EN;
output reg PERIPH_CLK_EN;
output reg OSC_RUN;
output reg SYS_RESET;
output reg [7:0] PORT_INIT;
output reg [7:0] SP_INIT;
output reg [7:0] SFR_INIT;
output reg SFR_CLEAR;
output reg SERIAL_BUFFER_HOLD;

// ----------------------------------------------------------------
// Decode helpers
// ----------------------------------------------------------------
function addr_known;
	input [11:0] a;
	begin
		addr_known = (a == `WPR_ADDR_WDT_CTRL) ||
			(a == `WPR_ADDR_PWR_CTRL) ||
			(a == `WPR_ADDR_STATUS) ||
			(a == `WPR_ADDR_WDT_COUNT);
	end
endfunction

// Prescale code n selects a divide of 2^(n+1)
function ps_tick;
	input [7:0] cnt;
	input [2:0] sel;
	begin
		ps_tick = ((cnt & ((8'h02 << sel) - 8'h01)) ==
			((8'h02 << sel) - 8'h01));
	end
endfunction

// ----------------------------------------------------------------
// Clock division and machine cycle phases
// ----------------------------------------------------------------
reg half_r;
reg [3:0] phase_r;
reg pwr_down_r;
wire mc_end;
wire rst_sample_en;
wire osc_en;
assign osc_en = ~pwr_down_r;
assign mc_end = osc_en & (phase_r == 4'hb);
assign rst_sample_en = osc_en & (phase_r == `WPR_SAMPLE_PHASE);

always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN) begin
		half_r <= 1'b0;
		phase_r <= 4'h0;
	end else if (osc_en) begin
		half_r <= ~half_r;
		if (phase_r == 4'hb) begin
			phase_r <= 4'h0;
		end else begin
			phase_r <= phase_r + 4'h1;
		end
	end
end

// ----------------------------------------------------------------
// Reset pin sampling and deglitch
// ----------------------------------------------------------------
reg [1:0] rst_hist_r;
reg rst_ext_r;
reg [1:0] rst_lo_cnt_r;
always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN) begin
		rst_hist_r <= 2'b00;
		rst_ext_r <= 1'b0;
	end else if (pwr_down_r && EXT_RESET) begin
		// Oscillator restarts on reset while in power-down
		rst_hist_r <= 2'b00;
		rst_ext_r <= 1'b0;
	end else if (rst_sample_en) begin
		rst_hist_r <= {rst_hist_r[0], EXT_RESET};
		// Two consecutive high samples needed
		if (rst_hist_r[0] && EXT_RESET) begin
			rst_ext_r <= 1'b1;
		end else if (!rst_hist_r[0] && !EXT_RESET) begin
			rst_ext_r <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg wdt_enable_r;
reg wdt_kick_r;
reg wdt_run_in_idle_r;
reg [2:0] wdt_ps_r;
reg idle_request_r;
reg gf1_r;
reg gf0_r;
reg power_on_flag_r;
reg [7:0] presc_r;
reg [13:0] wdt_cnt_r;
reg wdt_reset_r;
reg wdt_timeout_r;
reg por_seen_r;
reg [1:0] wake_sync_r;
wire chip_reset;
wire wr_acc;
wire rd_acc;
wire wdt_run;
wire wdt_tick;
assign chip_reset = rst_ext_r | wdt_reset_r | wake_sync_r[1];
assign wr_acc = PSEL & PENABLE & PWRITE & ~PREADY;
assign rd_acc = PSEL & PENABLE & ~PWRITE & ~PREADY;
assign wdt_run = wdt_enable_r &
	(~idle_request_r | wdt_run_in_idle_r) & ~pwr_down_r;
assign wdt_tick = wdt_run & mc_end & ps_tick(presc_r, wdt_ps_r);

// Power-down ends only on the reset pin, which restarts the oscillator
always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN) begin
		wake_sync_r <= 2'b00;
	end else begin
		wake_sync_r <= {wake_sync_r[0], pwr_down_r & EXT_RESET};
	end
end

always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN) begin
		por_seen_r <= 1'b0;
		power_on_flag_r <= 1'b0;
	end else begin
		por_seen_r <= 1'b1;
		if (!por_seen_r && !POR_N) begin
			power_on_flag_r <= 1'b1;
		end else if (wr_acc && PADDR == `WPR_ADDR_PWR_CTRL) begin
			power_on_flag_r <= PWDATA[`WPR_PWR_FLAG_BIT];
		end
	end
end

always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN) begin
		wdt_enable_r <= 1'b0;
		wdt_kick_r <= 1'b0;
		wdt_run_in_idle_r <= 1'b0;
		wdt_ps_r <= 3'h0;
		idle_request_r <= 1'b0;
		pwr_down_r <= 1'b0;
		gf1_r <= 1'b0;
		gf0_r <= 1'b0;
	end else if (chip_reset) begin
		wdt_enable_r <= 1'b0;
		wdt_kick_r <= 1'b0;
		wdt_run_in_idle_r <= 1'b0;
		wdt_ps_r <= 3'h0;
		idle_request_r <= 1'b0;
		pwr_down_r <= 1'b0;
		gf1_r <= 1'b0;
		gf0_r <= 1'b0;
	end else begin
		if (idle_request_r && IRQ_PENDING) begin
			idle_request_r <= 1'b0;
		end
		if (wdt_kick_r && mc_end) begin
			wdt_kick_r <= 1'b0;
		end
		if (wr_acc && PADDR == `WPR_ADDR_WDT_CTRL) begin
			wdt_enable_r <= PWDATA[`WPR_WDT_ENABLE_BIT];
			wdt_run_in_idle_r <= PWDATA[`WPR_WDT_IDLE_BIT];
			wdt_ps_r <= PWDATA[`WPR_WDT_PS_HI:`WPR_WDT_PS_LO];
			// Zero leaves a pending kick alone
			if (PWDATA[`WPR_WDT_KICK_BIT]) begin
				wdt_kick_r <= 1'b1;
			end
		end
		if (wr_acc && PADDR == `WPR_ADDR_PWR_CTRL) begin
			gf1_r <= PWDATA[`WPR_PWR_GF1_BIT];
			gf0_r <= PWDATA[`WPR_PWR_GF0_BIT];
			if (PWDATA[`WPR_PWR_DOWN_BIT]) begin
				pwr_down_r <= 1'b1;
			end
			if (PWDATA[`WPR_PWR_IDLE_BIT] && !IRQ_PENDING) begin
				idle_request_r <= 1'b1;
			end
		end
	end
end

// ----------------------------------------------------------------
// Watchdog prescaler and timer
// ----------------------------------------------------------------
always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN) begin
		presc_r <= 8'h00;
		wdt_cnt_r <= 14'h0000;
		wdt_reset_r <= 1'b0;
		wdt_timeout_r <= 1'b0;
	end else begin
		wdt_reset_r <= 1'b0;
		// A time-out in the same cycle as the clear wins below
		if (wr_acc && PADDR == `WPR_ADDR_STATUS && PWDATA[0] &&
			!wdt_reset_r) begin
			wdt_timeout_r <= 1'b0;
		end
		if (chip_reset) begin
			presc_r <= 8'h00;
			wdt_cnt_r <= 14'h0000;
		end else if (wdt_kick_r && mc_end) begin
			presc_r <= 8'h00;
			wdt_cnt_r <= 14'h0000;
		end else if (wdt_run && mc_end) begin
			presc_r <= presc_r + 8'h01;
			if (wdt_tick) begin
				wdt_cnt_r <= wdt_cnt_r + 14'h0001;
				if (wdt_cnt_r == 14'h3fff) begin
					wdt_reset_r <= 1'b1;
					wdt_timeout_r <= 1'b1;
				end
			end
		end
	end
end

// ----------------------------------------------------------------
// APB read path and outputs
// ----------------------------------------------------------------
always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN) begin
		PRDATA <= 32'h00000000;
		PREADY <= 1'b0;
		PSLVERR <= 1'b0;
	end else begin
		PREADY <= PSEL & PENABLE & ~PREADY;
		PSLVERR <= PSEL & PENABLE & ~PREADY & ~addr_known(PADDR);
		PRDATA <= 32'h00000000;
		if (rd_acc) begin
			case (PADDR)
			`WPR_ADDR_WDT_CTRL: PRDATA <= {24'h000000, wdt_enable_r,
				wdt_kick_r, wdt_run_in_idle_r, 2'b00, wdt_ps_r};
			`WPR_ADDR_PWR_CTRL: PRDATA <= {27'h0000000,
				power_on_flag_r, gf1_r, gf0_r, pwr_down_r, idle_request_r};
			`WPR_ADDR_STATUS: PRDATA <= {29'h00000000, rst_ext_r,
				idle_request_r, wdt_timeout_r};
			`WPR_ADDR_WDT_COUNT: PRDATA <= {18'h00000, wdt_cnt_r};
			default: PRDATA <= 32'h00000000;
			endcase
		end
	end
end

always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN) begin
		CLK_HALF_EN <= 1'b0;
		CPU_CLK_EN <= 1'b0;
		PERIPH_CLK_EN <= 1'b0;
		OSC_RUN <= 1'b0;
		SYS_RESET <= 1'b1;
		PORT_INIT <= `WPR_PORT_RESET;
		SP_INIT <= `WPR_SP_RESET;
		SFR_INIT <= `WPR_SFR_RESET;
		SFR_CLEAR <= 1'b1;
		SERIAL_BUFFER_HOLD <= 1'b1;
	end else begin
		CLK_HALF_EN <= osc_en & half_r;
		CPU_CLK_EN <= osc_en & half_r & ~idle_request_r;
		PERIPH_CLK_EN <= osc_en & half_r;
		OSC_RUN <= osc_en;
		SYS_RESET <= chip_reset;
		PORT_INIT <= `WPR_PORT_RESET;
		SP_INIT <= `WPR_SP_RESET;
		SFR_INIT <= `WPR_SFR_RESET;
		SFR_CLEAR <= chip_reset;
		SERIAL_BUFFER_HOLD <= 1'b1;
	end
end
endmodule // wpr_top

// >>> tb/wpr_monitor.sv
// Port checker for the watchdog, power and reset block
`timescale 1ns/1ns
module wpr_monitor (
	input wire CLK_SYS,
	input wire RESETN,
	input wire EXT_RESET,
	input wire CLK_HALF_EN,
	input wire CPU_CLK_EN,
	input wire PERIPH_CLK_EN,
	input wire OSC_RUN,
	input wire SYS_RESET,
	input wire [7:0] PORT_INIT,
	input wire [7:0] SP_INIT,
	input wire [7:0] SFR_INIT,
	input wire SFR_CLEAR,
	input wire SERIAL_BUFFER_HOLD
);
// ----
// Reset pin high time, cleared in power-down since sampling stops there
// ----
reg [5:0] hi_cnt_r;
always @(posedge CLK_SYS or negedge RESETN) begin
	if (!RESETN)
		hi_cnt_r <= 6'h00;
	else if (!EXT_RESET || !OSC_RUN)
		hi_cnt_r <= 6'h00;
	else if (hi_cnt_r != 6'h3f)
		hi_cnt_r <= hi_cnt_r + 6'h01;
end
default clocking cb @(posedge CLK_SYS); endclocking
default disable iff (!RESETN);
a_half_rate: assert property (
	$past(RESETN) && $past(OSC_RUN) && OSC_RUN
	|-> CLK_HALF_EN != $past(CLK_HALF_EN))
	else $error("half rate enable not alternating");
a_cpu_gated: assert property (CPU_CLK_EN |-> CLK_HALF_EN)
	else $error("processor enable outside half rate");
a_periph_run: assert property (PERIPH_CLK_EN == CLK_HALF_EN)
	else $error("peripheral enable differs from half rate");
a_pd_stops: assert property (
	!OSC_RUN && !$past(OSC_RUN)
	|-> !CLK_HALF_EN && !PERIPH_CLK_EN && !CPU_CLK_EN)
	else $error("clock enable active in power-down");
a_pd_hold: assert property (
	$past(RESETN) && !OSC_RUN && !EXT_RESET
	&& !$past(EXT_RESET) && !$past(EXT_RESET, 2)
	|=> !OSC_RUN)
	else $error("power-down left without reset");
a_init_vals: assert property (
	PORT_INIT == 8'hff && SP_INIT == 8'h07 && SFR_INIT == 8'h00
	&& SERIAL_BUFFER_HOLD == 1'h1)
	else $error("reset load values wrong");
a_clear_follow: assert property (SFR_CLEAR == SYS_RESET)
	else $error("register clear differs from chip reset");
a_ext_reset: assert property (hi_cnt_r >= 6'h24 |-> SYS_RESET)
	else $error("held reset pin did not reset chip");
endmodule // wpr_monitor
bind wpr_top wpr_monitor u_mon (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
	.EXT_RESET(EXT_RESET), .CLK_HALF_EN(CLK_HALF_EN),
	.CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
	.OSC_RUN(OSC_RUN), .SYS_RESET(SYS_RESET), .PORT_INIT(PORT_INIT),
	.SP_INIT(SP_INIT), .SFR_INIT(SFR_INIT), .SFR_CLEAR(SFR_CLEAR),
	.SERIAL_BUFFER_HOLD(SERIAL_BUFFER_HOLD));

// >>> tb/testbench.sv
// Self-checking bench for the watchdog, power and reset block
`timescale 1ns/1ns
`include "wpr_consts.vh"
module testbench;
localparam [11:0] A_CTL = `WPR_ADDR_WDT_CTRL;
localparam [11:0] A_PWR = `WPR_ADDR_PWR_CTRL;
localparam [11:0] A_CNT = `WPR_ADDR_WDT_COUNT;
reg clk_sys = 1'b0;
reg resetn = 1'b0, por_n = 1'b0, ext_reset = 1'b0, irq_pending = 1'b0;
reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
reg [11:0] paddr = 12'h000;
reg [31:0] pwdata = 32'h00000000;
wire [31:0] prdata;
wire pready, pslverr, half_en, cpu_en, per_en, osc_run, sys_reset;
wire sfr_clear, sb_hold;
wire [7:0] port_init, sp_init, sfr_init;
integer n_errors = 0, n_checks = 0, ps, ri;
reg [31:0] rd, c1, c2, k;
reg err;
always #4 clk_sys = ~clk_sys;
wpr_top DUT (.CLK_SYS(clk_sys), .RESETN(resetn), .POR_N(por_n),
	.EXT_RESET(ext_reset), .IRQ_PENDING(irq_pending), .PSEL(psel),
	.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
	.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
	.CLK_HALF_EN(half_en), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en),
	.OSC_RUN(osc_run), .SYS_RESET(sys_reset), .PORT_INIT(port_init),
	.SP_INIT(sp_init), .SFR_INIT(sfr_init), .SFR_CLEAR(sfr_clear),
	.SERIAL_BUFFER_HOLD(sb_hold));
// ----
// Tasks
// ----
task wrap_up;
	$display("checks %0d errors %0d", n_checks, n_errors);
	if (n_errors == 0 && n_checks > 0)
		$display("Test passed");
	else
		$display("Test failed");
	$finish;
endtask
task chk(input [31:0] g, input [31:0] e);
	n_checks = n_checks + 1;
	if (g !== e) begin
		n_errors = n_errors + 1;
		$display("[ERR] %0t got %h exp %h", $time, g, e);
	end
endtask
task cyc(input integer n);
	repeat (n) @(posedge clk_sys);
endtask
// Request held until the edge that samples pready high
task apb(input w, input [11:0] a, input [31:0] d);
	integer i;
	@(posedge clk_sys);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge clk_sys);
	penable <= 1'b1;
	i = 0;
	// Answer looked at mid-cycle, where it stands for the next edge
	do begin
		@(negedge clk_sys);
		i = i + 1;
	end while (pready !== 1'b1 && i < 50);
	rd = prdata;
	err = pslverr;
	@(posedge clk_sys);
	psel <= 1'b0;
	penable <= 1'b0;
	if (pready !== 1'b1) begin
		n_errors = n_errors + 1;
		wrap_up;
	end
endtask
// ----
// Tests
// ----
initial begin
	cyc(16);
	resetn <= 1'b1;
	cyc(1);
	por_n <= 1'b1;
	chk({8'h00, port_init, sp_init, sfr_init}, 32'h00ff0700);
	apb(0, A_PWR, 0);
	chk(rd, 32'h10);
	apb(0, 12'h010, 0);
	chk({rd[30:0], err}, 32'h1);
	cyc(100);
	apb(0, A_CNT, 0);
	chk(rd, 0);
	$display("test reset done");
	for (ps = 0; ps < 8; ps = ps + 1) begin
		apb(1, A_CTL, 32'hc0 | ps);
		cyc(108 << ps);
		apb(0, A_CNT, 0);
		chk(rd >= 3 && rd <= 5, 1);
		apb(0, A_CTL, 0);
		chk(rd, 32'h80 | ps);
	end
	c1 = rd;
	apb(0, A_CNT, 0);
	c1 = rd;
	apb(1, A_CTL, 32'h87);
	apb(0, A_CNT, 0);
	chk(rd >= c1, 1);
	apb(1, A_CTL, 32'hc7);
	cyc(30);
	apb(0, A_CNT, 0);
	chk(rd, 0);
	$display("test watchdog done");
	for (ri = 0; ri < 2; ri = ri + 1) begin
		apb(1, A_CTL, 32'hc0 | (ri << 5));
		apb(1, A_PWR, 32'h01);
		apb(0, A_CNT, 0);
		c1 = rd;
		k = 0;
		c2 = 0;
		repeat (240) begin
			@(negedge clk_sys);
			k = k + cpu_en;
			c2 = c2 + per_en;
		end
		chk(k, 0);
		chk(c2, 120);
		apb(0, A_CNT, 0);
		chk(rd != c1, ri);
		irq_pending <= 1'b1;
		cyc(8);
		irq_pending <= 1'b0;
		apb(0, A_PWR, 0);
		chk(rd, 0);
	end
	$display("test idle done");
	apb(1, A_PWR, 32'h1c);
	ext_reset <= 1'b1;
	cyc(5);
	ext_reset <= 1'b0;
	cyc(40);
	apb(0, A_PWR, 0);
	chk(rd, 32'h1c);
	ext_reset <= 1'b1;
	cyc(40);
	ext_reset <= 1'b0;
	cyc(60);
	apb(0, A_PWR, 0);
	chk(rd, 32'h10);
	apb(0, A_CTL, 0);
	chk(rd, 0);
	apb(0, A_CNT, 0);
	chk(rd, 0);
	$display("test external reset done");
	apb(1, A_PWR, 32'h02);
	cyc(10);
	chk(osc_run, 0);
	irq_pending <= 1'b1;
	cyc(20);
	chk(osc_run, 0);
	irq_pending <= 1'b0;
	ext_reset <= 1'b1;
	cyc(40);
	ext_reset <= 1'b0;
	cyc(60);
	chk(osc_run, 1);
	apb(0, A_PWR, 0);
	chk(rd, 0);
	$display("test power-down done");
	wrap_up;
end
endmodule // testbench
